// *** shared/adcpo_pkg.sv ***
// Shared constants and types for the parallel output converter control.
// Assumes a 40 MHz system clock; encode arrives as a sampled input.
package adcpo_pkg;

  localparam int unsigned SAMPLE_WIDTH   = 10;
  localparam int unsigned PIPE_STAGES    = 5;
  localparam logic [31:0] ADDR_CTRL      = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS    = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_STAT  = 32'h0000_0008;
  localparam logic [31:0] ADDR_IRQ_CLR   = 32'h0000_000C;
  localparam logic [31:0] ADDR_IRQ_EN    = 32'h0000_0010;
  localparam logic [31:0] ADDR_ANALOG    = 32'h0000_0014;
  localparam int unsigned CTRL_PDS_BIT   = 0;
  localparam int unsigned CTRL_OEN_BIT   = 1;
  localparam int unsigned CTRL_MODE_LSB  = 2;
  localparam int unsigned IRQ_SAMPLE_BIT = 0;
  localparam int unsigned IRQ_RANGE_BIT  = 1;
  localparam logic [3:0]  CTRL_RESET     = 4'h2;
  localparam logic [1:0]  IRQ_EN_RESET   = 2'h0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Four levels of the format pin, lowest first
  typedef enum logic [1:0] {
    FMT_OB_STAB_OFF = 2'h0,
    FMT_OB_STAB_ON  = 2'h1,
    FMT_TC_STAB_ON  = 2'h2,
    FMT_TC_STAB_OFF = 2'h3
  } adcpo_format_type;

  typedef enum logic [1:0] {
    OP_NORMAL, OP_HIZ, OP_NAP, OP_SLEEP
  } adcpo_op_type;

  // Parallel output group with per-group enable
  typedef struct packed {
    logic [9:0] sample_bits;
    logic       range_exceeded_flag;
    logic       data_valid_strobe;
    logic       out_en;
  } adcpo_out_type;

  // One analog conversion result entering the pipeline
  typedef struct packed {
    logic [9:0] code;
    logic       over;
    logic       under;
  } adcpo_raw_type;

endpackage

// *** logic/adcpo_top.sv ***
// Digital control and parallel output side of a 10-bit sampling converter.
// Assumes encode_pos/encode_neg arrive asynchronous to clk (sampled).
//
// What this block does
// [RL1] Sample on each rising encode edge while converting (normal or output disable)
// [RL2] Normal mode drives all outputs
// [RL3] Output disable keeps converting, outputs high-Z
// [RL4] Power-down with outputs enabled naps, high-Z
// [RL5] Power-down with outputs disabled sleeps, high-Z
// [RL6] Capture logic latches on strobe fall
// [RL7] Ten-bit word, bit 9 is MSB
// [RL8] Overflow flag marks out-of-range sample
// [RL9] Format pin selects coding and stabilizer
// [RL10] Zero input alternates all-zero, all-one codes in two's complement
// [RL11] Result appears five encode cycles later
// [RL12] Word, flag, strobe update together
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module adcpo_top
  import adcpo_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  encode_pos,
  input  wire logic                  encode_neg,
  input  wire adcpo_pkg::adcpo_raw_type analog_in,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output adcpo_pkg::adcpo_out_type   out_q,
  output logic                       irq_q
);
  import adcpo_pkg::*;

  // ---------------------------------------------------------------
  // Encode input synchroniser and edge detect
  // ---------------------------------------------------------------
  logic [1:0] enc_p_sync_q;
  logic [1:0] enc_n_sync_q;
  logic       enc_last_q;
  adcpo_raw_type raw_sync1_q;
  adcpo_raw_type raw_sync2_q;
  wire enc_diff;
  assign enc_diff = enc_p_sync_q[1] & ~enc_n_sync_q[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enc_p_sync_q <= 2'h0;
      enc_n_sync_q <= 2'h0;
      enc_last_q   <= 1'b0;
      raw_sync1_q  <= '0;
      raw_sync2_q  <= '0;
    end else begin
      enc_p_sync_q <= {enc_p_sync_q[0], encode_pos};
      enc_n_sync_q <= {enc_n_sync_q[0], encode_neg};
      enc_last_q   <= enc_diff;
      raw_sync1_q  <= analog_in;
      raw_sync2_q  <= raw_sync1_q;
    end
  end

  wire enc_rise;
  assign enc_rise = enc_diff & ~enc_last_q;  // [RL1]
  wire enc_fall;
  assign enc_fall = ~enc_diff & enc_last_q;

  // ---------------------------------------------------------------
  // Control register and operating mode
  // ---------------------------------------------------------------
  logic [3:0] ctrl_q;
  wire        pds;
  wire        oe_n;
  adcpo_format_type fmt;
  adcpo_op_type     op_mode;
  assign pds  = ctrl_q[CTRL_PDS_BIT];
  assign oe_n = ctrl_q[CTRL_OEN_BIT];
  assign fmt  = adcpo_format_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign op_mode = pds ? (oe_n ? OP_SLEEP : OP_NAP)   // [RL4] [RL5]
                       : (oe_n ? OP_HIZ : OP_NORMAL); // [RL2] [RL3]
  wire converting;
  assign converting = (op_mode == OP_NORMAL) || (op_mode == OP_HIZ);
  wire twos_comp;
  assign twos_comp = (fmt == FMT_TC_STAB_ON) || (fmt == FMT_TC_STAB_OFF);
  wire stab_on;
  assign stab_on = (fmt == FMT_OB_STAB_ON) || (fmt == FMT_TC_STAB_ON);

  // ---------------------------------------------------------------
  // Five stage conversion pipeline
  // ---------------------------------------------------------------
  logic [SAMPLE_WIDTH-1:0] pipe_code_q [PIPE_STAGES];
  logic [PIPE_STAGES-1:0]  pipe_ovr_q;
  logic [PIPE_STAGES-1:0]  pipe_vld_q;
  wire  [SAMPLE_WIDTH-1:0] coded;
  // Two's complement is offset binary with the MSB inverted
  assign coded = twos_comp ? {~raw_sync2_q.code[9], raw_sync2_q.code[8:0]}
                           : raw_sync2_q.code;  // [RL9] [RL10]
  wire  ovr_in;
  assign ovr_in = raw_sync2_q.over | raw_sync2_q.under;  // [RL8]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe_code_q[i] <= '0;
      end
      pipe_ovr_q <= '0;
      pipe_vld_q <= '0;
    end else if (enc_rise && converting) begin  // [RL1] [RL11]
      pipe_code_q[0] <= coded;
      for (int i = 1; i < PIPE_STAGES; i++) begin
        pipe_code_q[i] <= pipe_code_q[i-1];
      end
      pipe_ovr_q <= {pipe_ovr_q[PIPE_STAGES-2:0], ovr_in};
      pipe_vld_q <= {pipe_vld_q[PIPE_STAGES-2:0], 1'b1};
    end else if (!converting) begin
      pipe_vld_q <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Output register: word and flag update at encode rise, strobe
  // follows encode so its falling edge sits mid-word
  // ---------------------------------------------------------------
  wire out_load;
  assign out_load = enc_rise && converting && pipe_vld_q[PIPE_STAGES-1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      if (out_load) begin  // [RL12] [RL7]
        out_q.sample_bits         <= pipe_code_q[PIPE_STAGES-1];
        out_q.range_exceeded_flag <= pipe_ovr_q[PIPE_STAGES-1];  // [RL8]
      end
      if (out_load) begin
        out_q.data_valid_strobe <= 1'b1;
      end else if (enc_fall) begin
        out_q.data_valid_strobe <= 1'b0;  // [RL6]
      end
      out_q.out_en <= (op_mode == OP_NORMAL);  // [RL2] [RL3]
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, clear and enable
  // ---------------------------------------------------------------
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [1:0] irq_clr;
  wire  [1:0] irq_set;
  assign irq_set = {out_load & pipe_ovr_q[PIPE_STAGES-1], out_load};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 2'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;  // set wins
      irq_q      <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  wire aw_take;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take;
  assign w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire;
  assign wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire wr_ctrl;
  assign wr_ctrl = wr_fire && awaddr_q == ADDR_CTRL && wstrb_q[0];
  wire wr_clr;
  assign wr_clr = wr_fire && awaddr_q == ADDR_IRQ_CLR && wstrb_q[0];
  wire wr_en;
  assign wr_en = wr_fire && awaddr_q == ADDR_IRQ_EN && wstrb_q[0];
  wire wr_ok;
  assign wr_ok = awaddr_q == ADDR_CTRL || awaddr_q == ADDR_IRQ_CLR
              || awaddr_q == ADDR_IRQ_EN;
  assign irq_clr = wr_clr ? wdata_q[1:0] : 2'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      ctrl_q        <= CTRL_RESET;
      irq_en_q      <= IRQ_EN_RESET;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_q & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[3:0];
      end
      if (wr_en) begin
        irq_en_q <= wdata_q[1:0];
      end
    end
  end

  wire [31:0] rd_mux;
  wire        rd_ok;
  assign rd_ok = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_STATUS
              || s_axi_araddr == ADDR_IRQ_STAT || s_axi_araddr == ADDR_IRQ_EN
              || s_axi_araddr == ADDR_ANALOG;
  assign rd_mux =
    (s_axi_araddr == ADDR_CTRL)     ? {28'h0, ctrl_q} :
    (s_axi_araddr == ADDR_STATUS)   ? {26'h0, stab_on, twos_comp,
                                       op_mode, out_q.data_valid_strobe,
                                       converting} :
    (s_axi_araddr == ADDR_IRQ_STAT) ? {30'h0, irq_stat_q} :
    (s_axi_araddr == ADDR_IRQ_EN)   ? {30'h0, irq_en_q} :
    (s_axi_araddr == ADDR_ANALOG)   ? {21'h0, out_q.range_exceeded_flag,
                                       out_q.sample_bits} :
    32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arready & s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_load;
    out_load;
  endsequence

  a_strobe_rise_load: assert property (  // [RL12]
    @(posedge clk) disable iff (rst) s_load |=> out_q.data_valid_strobe)
    else $error("strobe not raised after load");

  a_word_from_pipe: assert property (  // [RL7]
    @(posedge clk) disable iff (rst)
    s_load |=> out_q.sample_bits == $past(pipe_code_q[PIPE_STAGES-1]))
    else $error("word not taken from last stage");

  a_flag_from_pipe: assert property (  // [RL8]
    @(posedge clk) disable iff (rst)
    s_load |=> out_q.range_exceeded_flag == $past(pipe_ovr_q[PIPE_STAGES-1]))
    else $error("flag not taken from last stage");

  a_word_stable_hold: assert property (  // [RL12]
    @(posedge clk) disable iff (rst)
    !out_load |=> $stable(out_q.sample_bits))
    else $error("word changed without load");

  a_normal_drives: assert property (  // [RL2]
    @(posedge clk) disable iff (rst) (!pds && !oe_n) |=> out_q.out_en)
    else $error("outputs not driven in normal mode");

  a_hiz_outputs: assert property (  // [RL3]
    @(posedge clk) disable iff (rst) oe_n |=> !out_q.out_en)
    else $error("outputs driven while disabled");

  a_nap_hiz: assert property (  // [RL4]
    @(posedge clk) disable iff (rst)
    (pds && !oe_n) |-> op_mode == OP_NAP ##1 !out_q.out_en)
    else $error("nap mode not entered");

  a_sleep_hiz: assert property (  // [RL5]
    @(posedge clk) disable iff (rst)
    (pds && oe_n) |-> op_mode == OP_SLEEP ##1 !out_q.out_en)
    else $error("sleep mode not entered");

  a_sample_on_rise: assert property (  // [RL1]
    @(posedge clk) disable iff (rst)
    (enc_rise && converting) |=> pipe_code_q[0] == $past(coded))
    else $error("sample not taken on encode rise");

  a_twos_msb: assert property (  // [RL9] [RL10]
    @(posedge clk) disable iff (rst)
    twos_comp |-> coded[9] == ~raw_sync2_q.code[9])
    else $error("two's complement coding wrong");

  a_strobe_falls: assert property (  // [RL6]
    @(posedge clk) disable iff (rst)
    (enc_fall && !out_load) |=> !out_q.data_valid_strobe)
    else $error("strobe not lowered on encode fall");

  a_pipe_five: assert property (  // [RL11]
    @(posedge clk) disable iff (rst) s_load |-> pipe_vld_q == 5'h1F)
    else $error("load before five samples");

endmodule

// *** dv/adcpo_capture.sv ***
// Capture logic model standing on the far side of the output pins.
// Assumes pins float to Z while the converter drivers are off.
`timescale 1ns/1ps
module adcpo_capture (
  input  wire logic [9:0] sample_bits,
  input  wire logic       range_exceeded_flag,
  input  wire logic       data_valid_strobe,
  output logic [9:0]      cap_word,
  output logic            cap_flag,
  output int              cap_count
);
  logic prev_strobe = 1'b0;
  initial cap_count = 0;
  // Latch only on a true high-to-low strobe edge
  always @(data_valid_strobe) begin
    if (prev_strobe === 1'b1 && data_valid_strobe === 1'b0) begin
      cap_word  = sample_bits;
      cap_flag  = range_exceeded_flag;
      cap_count = cap_count + 1;
    end
    prev_strobe = data_valid_strobe;
  end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench: register bus master, encode and sample source.
// Assumes the package constants and the capture model beside it.
`timescale 1ns/1ps
module tb_top;
  import adcpo_pkg::*;
  logic          clk;
  logic          rst;
  logic          enc;
  adcpo_raw_type ain;
  logic [31:0]   awaddr, wdata, araddr, rdata;
  logic          awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp;
  adcpo_out_type oq;
  logic          irq;
  tri   [11:0]   pins;
  logic [9:0]    cw;
  logic          cf;
  int            cc, n0;
  int            fail_count = 0;
  int            samples_checked = 0;
  int            rises = 0, ph = 0, seen = 0;
  logic          chk_on = 1'b0, alt = 1'b0, twos = 1'b0;
  logic [9:0]    code_nx = 10'h000;
  adcpo_raw_type hist [0:1023];

  assign pins = oq.out_en ? {oq.sample_bits, oq.range_exceeded_flag,
                             oq.data_valid_strobe} : 12'hZZZ;

  adcpo_top u_dut (.clk(clk), .rst(rst), .encode_pos(enc),
    .encode_neg(~enc), .analog_in(ain), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .out_q(oq), .irq_q(irq));

  adcpo_capture u_cap (.sample_bits(pins[11:2]),
    .range_exceeded_flag(pins[1]), .data_valid_strobe(pins[0]),
    .cap_word(cw), .cap_flag(cf), .cap_count(cc));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Encode at 200 ns, sample source, history
  // ----------------------------------------
  always @(posedge clk) begin
    ph  <= (ph + 1) % 8;
    enc <= (ph < 4);
    if (ph == 0) begin
      hist[rises] <= ain;
      rises       <= rises + 1;
    end
    if (ph == 4) begin
      ain.code  <= code_nx;
      ain.over  <= (rises % 7 == 3) && !alt;
      ain.under <= (rises % 11 == 5) && !alt;
      code_nx   <= alt ? (code_nx == 10'h200 ? 10'h1FF : 10'h200)
                       : code_nx + 10'h0C3;
    end
  end

  // Compare each captured word, while chk_on is set, with the sample taken five rises before
  always @(posedge clk) begin
    if (cc != seen) begin
      seen <= cc;
      if (chk_on) begin
        chk({22'h0, cw},
            {22'h0, hist[rises-6].code ^ {twos, 9'h000}},
            "word");
        chk({31'h0, cf},
            {31'h0, hist[rises-6].over | hist[rises-6].under},
            "flag");
      end
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [31:0] a, m, exp, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata & m, exp, "read data");
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask

  task automatic wait_rises(input int n);
    int m;
    m = rises + n;
    while (rises < m) @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    enc = 1'b0;
    ain = '0;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, 32'hF, {28'h0, CTRL_RESET}, RESP_OKAY);
    rd(ADDR_IRQ_EN, 32'h3, {30'h0, IRQ_EN_RESET}, RESP_OKAY);
    rd(32'h0000_0040, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
    wr(32'h0000_0040, 32'h1, RESP_SLVERR);
    chk({31'h0, oq.out_en}, 32'h0, "reset drive");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, i, RESP_OKAY);
      rd(ADDR_STATUS, 32'hD, {28'h0, i[0], i[1], 1'b0, ~i[0]},
         RESP_OKAY);
      chk({31'h0, oq.out_en}, {31'h0, i == 0},
          "pin drive");
    end
    for (int f = 0; f < 4; f++) begin
      alt  <= f[1];
      twos <= f[1];
      wr(ADDR_CTRL, f << 2, RESP_OKAY);
      rd(ADDR_STATUS, 32'h30, {26'h0, f == 1 || f == 2, f[1], 4'h0},
         RESP_OKAY);
      wait_rises(7);
      chk_on <= 1'b1;
      n0 = cc;
      wait_rises(10);
      chk_on <= 1'b0;
      chk(cc - n0, 32'd10, "strobes per rise");
    end
    alt <= 1'b0;
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    wr(ADDR_IRQ_CLR, 32'h3, RESP_OKAY);
    rd(ADDR_IRQ_STAT, 32'h3, 32'h0, RESP_OKAY);
    wr(ADDR_IRQ_EN, 32'h3, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq idle");
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    wait_rises(14);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(ADDR_IRQ_STAT, 32'h3, 32'h3, RESP_OKAY);
    wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
    // Interrupt output is registered one edge after the enable
    @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    results();
  end
endmodule
